// *** hw/config_fuse_consts.svh ***
// Constants for the configuration fuse protection block: addresses, field positions and defaults.
`ifndef CONFIG_FUSE_CONSTS_SVH
`define CONFIG_FUSE_CONSTS_SVH

// ****************************************************************
// Byte addresses of the configuration bytes held by this block.
// ****************************************************************
`define CFG_WDT_ADDR 22'h300003
`define CFG_DBG_ADDR 22'h300006
`define CFG_CP_LO_ADDR 22'h300008
`define CFG_CP_HI_ADDR 22'h300009
`define CFG_WR_LO_ADDR 22'h30000A
`define CFG_WR_HI_ADDR 22'h30000B
`define CFG_TR_LO_ADDR 22'h30000C
`define CFG_TR_HI_ADDR 22'h30000D

// ****************************************************************
// Implemented bits of each byte; the unprogrammed value is the same pattern.
// ****************************************************************
`define CFG_WDT_MASK 8'h0F
`define CFG_DBG_MASK 8'h85
`define CFG_CP_LO_MASK 8'h0F
`define CFG_CP_HI_MASK 8'hC0
`define CFG_WR_LO_MASK 8'h0F
`define CFG_WR_HI_MASK 8'hE0
`define CFG_TR_LO_MASK 8'h0F
`define CFG_TR_HI_MASK 8'h40

// ****************************************************************
// Field positions.
// ****************************************************************
`define WDT_EN_BIT 0
`define WDT_PS_LSB 1
`define WDT_PS_MSB 3
`define DEBUG_BIT 7
`define LOWV_PROG_BIT 2
`define STACK_RST_BIT 0
`define EEPROM_BIT 7
`define BOOT_BIT 6
`define CFG_WP_BIT 5

// ****************************************************************
// Memory regions.
// ****************************************************************
`define BOOT_END 22'h0001FF
`define BLK0_END 22'h001FFF
`define BLK1_END 22'h003FFF
`define BLK2_END 22'h005FFF
`define BLK3_END 22'h007FFF
`define CFG_BASE 22'h300000
`define CFG_WP_END 22'h3000FF

`endif

// *** hw/config_fuse_pkg.sv ***
// Types shared by the configuration fuse protection modules.
package config_fuse_pkg;

   typedef logic [7:0] byte_type;
   typedef logic [21:0] addr_type;

   typedef enum logic [2:0] {
      REGION_BOOT,
      REGION_BLK0,
      REGION_BLK1,
      REGION_BLK2,
      REGION_BLK3,
      REGION_FREE,
      REGION_CONFIG
   } region_type;

endpackage : config_fuse_pkg

// *** hw/fuse_view_if.sv ***
// Decoded view of the stored configuration bits, passed from the store to its users.
`timescale 1ns/1ps
interface fuse_view_if;
   logic [3:0] code_prot_n;
   logic [3:0] write_prot_n;
   logic [3:0] tread_prot_n;
   logic boot_code_n;
   logic boot_write_n;
   logic boot_tread_n;
   logic cfg_write_n;
   logic [2:0] wdt_sel;
   logic wdt_fuse_en;
   modport owner (output code_prot_n, write_prot_n, tread_prot_n, boot_code_n, boot_write_n,
                  boot_tread_n, cfg_write_n, wdt_sel, wdt_fuse_en);
   modport guard (input code_prot_n, write_prot_n, tread_prot_n, boot_code_n, boot_write_n,
                  boot_tread_n, cfg_write_n);
   modport wdog (input wdt_sel, wdt_fuse_en);
endinterface : fuse_view_if

// *** hw/region_guard.sv ***
// Address classification and protection decision for one table access.
`timescale 1ns/1ps
`include "config_fuse_consts.svh"
module region_guard
   import config_fuse_pkg::*;
(
   input wire addr_type i_tgt_addr,
   input wire addr_type i_exec_addr,
   input wire logic i_prog_mode,
   fuse_view_if.guard fuse,
   output logic o_cfg_hit,
   output logic o_rd_deny,
   output logic o_wr_deny
);

   function automatic region_type region_of(input addr_type a);
      region_type r;
      r = REGION_FREE;
      if (a <= `BOOT_END)
         r = REGION_BOOT;
      else if (a <= `BLK0_END)
         r = REGION_BLK0;
      else if (a <= `BLK1_END)
         r = REGION_BLK1;
      else if (a <= `BLK2_END)
         r = REGION_BLK2;
      else if (a <= `BLK3_END)
         r = REGION_BLK3;
      else if (a >= `CFG_BASE)
         r = REGION_CONFIG;
      return r;
   endfunction : region_of

   region_type tgt_region;
   region_type exec_region;
   logic [4:0] tgt_onehot;
   logic tgt_code_n;
   logic tgt_write_n;
   logic tgt_tread_n;
   logic same_region;
   logic cfg_wp_range;

   assign tgt_region = region_of(i_tgt_addr);
   assign exec_region = region_of(i_exec_addr);
   assign tgt_onehot = {tgt_region == REGION_BOOT, tgt_region == REGION_BLK3, tgt_region == REGION_BLK2,
                        tgt_region == REGION_BLK1, tgt_region == REGION_BLK0};
   // Each selected block takes its own protection bit; a region outside the blocks sees all ones.
   assign tgt_code_n = &({fuse.boot_code_n, fuse.code_prot_n} | ~tgt_onehot);
   assign tgt_write_n = &({fuse.boot_write_n, fuse.write_prot_n} | ~tgt_onehot);
   assign tgt_tread_n = &({fuse.boot_tread_n, fuse.tread_prot_n} | ~tgt_onehot);
   assign same_region = (tgt_region == exec_region);
   assign cfg_wp_range = (i_tgt_addr >= `CFG_BASE) && (i_tgt_addr <= `CFG_WP_END);

   assign o_cfg_hit = (tgt_region == REGION_CONFIG);
   // A programmer is stopped by code protection; running code by cross-block read protection.
   assign o_rd_deny = i_prog_mode ? ~tgt_code_n : (~tgt_tread_n & ~same_region);
   assign o_wr_deny = ~tgt_write_n | (cfg_wp_range & ~fuse.cfg_write_n);

endmodule : region_guard

// *** hw/watchdog_setup.sv ***
// Watchdog run state and postscale ratio derived from the configuration bits.
`timescale 1ns/1ps
module watchdog_setup
   import config_fuse_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_soft_en,
   fuse_view_if.wdog fuse,
   output logic o_run,
   output logic [7:0] o_divide
);

   logic run_d;
   logic [7:0] divide_d;

   assign run_d = fuse.wdt_fuse_en | i_soft_en;
   assign divide_d = 8'h01 << fuse.wdt_sel;

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_run <= 1'b1;
         o_divide <= 8'h80;
      end
      else
      begin
         o_run <= run_d;
         o_divide <= divide_d;
      end
   end

endmodule : watchdog_setup

// *** hw/config_fuse_protection.sv ***
// Configuration fuse bank with table access port and protection decisions.
`timescale 1ns/1ps
`include "config_fuse_consts.svh"
module config_fuse_protection
   import config_fuse_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_prog_mode,
   input wire logic i_tbl_rd,
   input wire logic i_tbl_wr,
   input wire addr_type i_tbl_addr,
   input wire byte_type i_tbl_wdata,
   input wire addr_type i_exec_addr,
   input wire byte_type i_mem_rdata,
   input wire logic i_soft_wdt_en,
   input wire logic i_lowv_entry_req,
   input wire logic i_stack_full,
   input wire logic i_stack_underflow,
   input wire logic i_ee_wr_req,
   output logic o_tbl_done,
   output byte_type o_tbl_rdata,
   output logic o_tbl_denied,
   output logic o_mem_wr,
   output addr_type o_mem_addr,
   output byte_type o_mem_wdata,
   output logic o_ee_wr,
   output logic o_ee_wr_blocked,
   output logic o_lowv_accept,
   output logic o_lowv_refused,
   output logic o_stack_reset,
   output logic o_portb_pin6_debug,
   output logic o_portb_pin7_debug,
   output logic [5:0] o_code_protect,
   output logic o_wdt_run,
   output logic [7:0] o_wdt_divide
);

   // ****************************************************************
   // Slot tables: one entry per stored configuration byte.
   // ****************************************************************
   localparam int NUM_SLOTS = 8;
   localparam addr_type SLOT_ADDR [0:NUM_SLOTS-1] = '{`CFG_WDT_ADDR, `CFG_DBG_ADDR, `CFG_CP_LO_ADDR,
      `CFG_CP_HI_ADDR, `CFG_WR_LO_ADDR, `CFG_WR_HI_ADDR, `CFG_TR_LO_ADDR, `CFG_TR_HI_ADDR};
   localparam byte_type SLOT_MASK [0:NUM_SLOTS-1] = '{`CFG_WDT_MASK, `CFG_DBG_MASK, `CFG_CP_LO_MASK,
      `CFG_CP_HI_MASK, `CFG_WR_LO_MASK, `CFG_WR_HI_MASK, `CFG_TR_LO_MASK, `CFG_TR_HI_MASK};
   localparam logic [NUM_SLOTS-1:0] SLOT_CLEAR_ONLY = 8'h0C;
   localparam byte_type USER_LOCK_BITS = 8'h01 << `CFG_WP_BIT;
   localparam int WDT_SLOT = 0;
   localparam int DBG_SLOT = 1;
   localparam int CP_LO_SLOT = 2;
   localparam int CP_HI_SLOT = 3;
   localparam int WR_LO_SLOT = 4;
   localparam int WR_HI_SLOT = 5;
   localparam int TR_LO_SLOT = 6;
   localparam int TR_HI_SLOT = 7;

   // ****************************************************************
   // Storage and decode.
   // ****************************************************************
   byte_type fuse_q [0:NUM_SLOTS-1];
   logic [NUM_SLOTS-1:0] slot_hit;
   byte_type slot_rdata [0:NUM_SLOTS-1];
   byte_type cfg_rdata;
   logic rd_go;
   logic wr_go;
   logic cfg_hit;
   logic rd_deny;
   logic wr_deny;
   logic cfg_wr_go;
   logic mem_wr_go;
   logic ee_write_n;
   logic ee_code_n;
   logic lowv_prog_en;
   logic stack_rst_en;
   logic stack_fault;

   fuse_view_if fuse ();

   // A read wins over a write presented in the same cycle; the write is dropped.
   assign rd_go = i_tbl_rd;
   assign wr_go = i_tbl_wr & ~i_tbl_rd;
   assign cfg_wr_go = wr_go & cfg_hit & ~wr_deny;
   assign mem_wr_go = wr_go & ~cfg_hit & ~wr_deny;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SLOTS; gi++)
      begin : g_slot
         byte_type new_val;
         byte_type lock_bits;
         byte_type store_val;

         assign slot_hit[gi] = (i_tbl_addr == SLOT_ADDR[gi]);
         // Clear-only bytes can only lose ones through this path.
         assign new_val = SLOT_CLEAR_ONLY[gi] ? (fuse_q[gi] & i_tbl_wdata) : i_tbl_wdata;
         assign lock_bits = (gi == WR_HI_SLOT && !i_prog_mode) ? USER_LOCK_BITS : 8'h00;
         assign store_val = ((new_val & ~lock_bits) | (fuse_q[gi] & lock_bits)) & SLOT_MASK[gi];
         assign slot_rdata[gi] = slot_hit[gi] ? (fuse_q[gi] & SLOT_MASK[gi]) : 8'h00;

         always_ff @(posedge i_mclk or negedge i_resetn)
         begin
            if (!i_resetn)
               fuse_q[gi] <= SLOT_MASK[gi];
            else if (cfg_wr_go && slot_hit[gi])
               fuse_q[gi] <= store_val;
         end
      end
   endgenerate

   // Bytes of the configuration space that are not held here read as zero.
   always_comb
   begin
      cfg_rdata = 8'h00;
      for (int k = 0; k < NUM_SLOTS; k++)
         cfg_rdata = cfg_rdata | slot_rdata[k];
   end

   // ****************************************************************
   // Decoded fuse view.
   // ****************************************************************
   assign fuse.wdt_sel = fuse_q[WDT_SLOT][`WDT_PS_MSB:`WDT_PS_LSB];
   assign fuse.wdt_fuse_en = fuse_q[WDT_SLOT][`WDT_EN_BIT];
   assign fuse.code_prot_n = fuse_q[CP_LO_SLOT][3:0];
   assign fuse.boot_code_n = fuse_q[CP_HI_SLOT][`BOOT_BIT];
   assign fuse.write_prot_n = fuse_q[WR_LO_SLOT][3:0];
   assign fuse.boot_write_n = fuse_q[WR_HI_SLOT][`BOOT_BIT];
   assign fuse.cfg_write_n = fuse_q[WR_HI_SLOT][`CFG_WP_BIT];
   assign fuse.tread_prot_n = fuse_q[TR_LO_SLOT][3:0];
   assign fuse.boot_tread_n = fuse_q[TR_HI_SLOT][`BOOT_BIT];
   assign ee_code_n = fuse_q[CP_HI_SLOT][`EEPROM_BIT];
   assign ee_write_n = fuse_q[WR_HI_SLOT][`EEPROM_BIT];
   assign lowv_prog_en = fuse_q[DBG_SLOT][`LOWV_PROG_BIT];
   assign stack_rst_en = fuse_q[DBG_SLOT][`STACK_RST_BIT];
   assign stack_fault = i_stack_full | i_stack_underflow;

   // ****************************************************************
   // Sub-blocks.
   // ****************************************************************
   region_guard u_guard (
      .i_tgt_addr(i_tbl_addr),
      .i_exec_addr(i_exec_addr),
      .i_prog_mode(i_prog_mode),
      .fuse(fuse.guard),
      .o_cfg_hit(cfg_hit),
      .o_rd_deny(rd_deny),
      .o_wr_deny(wr_deny)
   );

   watchdog_setup u_wdog (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_soft_en(i_soft_wdt_en),
      .fuse(fuse.wdog),
      .o_run(o_wdt_run),
      .o_divide(o_wdt_divide)
   );

   // ****************************************************************
   // Table access answer.
   // ****************************************************************
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_tbl_done <= 1'b0;
         o_tbl_rdata <= 8'h00;
         o_tbl_denied <= 1'b0;
      end
      else
      begin
         o_tbl_done <= rd_go | wr_go;
         o_tbl_denied <= (rd_go & ~cfg_hit & rd_deny) | (wr_go & wr_deny);
         if (rd_go)
            o_tbl_rdata <= cfg_hit ? cfg_rdata : (rd_deny ? 8'h00 : i_mem_rdata);
         else
            o_tbl_rdata <= 8'h00;
      end
   end

   // Program memory writes are forwarded one cycle later as a single byte strobe.
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_mem_wr <= 1'b0;
         o_mem_addr <= 22'h000000;
         o_mem_wdata <= 8'h00;
      end
      else
      begin
         o_mem_wr <= mem_wr_go;
         if (mem_wr_go)
         begin
            o_mem_addr <= i_tbl_addr;
            o_mem_wdata <= i_tbl_wdata;
         end
      end
   end

   // ****************************************************************
   // Data eeprom, programming entry and stack fault.
   // ****************************************************************
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_ee_wr <= 1'b0;
         o_ee_wr_blocked <= 1'b0;
         o_lowv_accept <= 1'b0;
         o_lowv_refused <= 1'b0;
         o_stack_reset <= 1'b0;
      end
      else
      begin
         o_ee_wr <= i_ee_wr_req & ee_write_n;
         o_ee_wr_blocked <= i_ee_wr_req & ~ee_write_n;
         o_lowv_accept <= i_lowv_entry_req & lowv_prog_en;
         o_lowv_refused <= i_lowv_entry_req & ~lowv_prog_en;
         o_stack_reset <= stack_fault & stack_rst_en;
      end
   end

   // ****************************************************************
   // Level outputs.
   // ****************************************************************
   // The debug pins are claimed only while the debugger bit is programmed low.
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_portb_pin6_debug <= 1'b0;
         o_portb_pin7_debug <= 1'b0;
         o_code_protect <= 6'h00;
      end
      else
      begin
         o_portb_pin6_debug <= ~fuse_q[DBG_SLOT][`DEBUG_BIT];
         o_portb_pin7_debug <= ~fuse_q[DBG_SLOT][`DEBUG_BIT];
         o_code_protect <= ~{ee_code_n, fuse.boot_code_n, fuse.code_prot_n};
      end
   end

endmodule : config_fuse_protection

// *** tb/config_fuse_properties.sv ***
// Port-level assertions for the configuration fuse block.
`timescale 1ns/1ps
module config_fuse_checker
   import config_fuse_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_tbl_rd,
   input wire logic i_tbl_wr,
   input wire addr_type i_tbl_addr,
   input wire byte_type i_tbl_wdata,
   input wire logic i_soft_wdt_en,
   input wire logic i_lowv_entry_req,
   input wire logic i_stack_full,
   input wire logic i_stack_underflow,
   input wire logic o_tbl_done,
   input wire byte_type o_tbl_rdata,
   input wire logic o_tbl_denied,
   input wire logic o_mem_wr,
   input wire logic o_lowv_accept,
   input wire logic o_lowv_refused,
   input wire logic o_stack_reset,
   input wire logic o_portb_pin6_debug,
   input wire logic o_portb_pin7_debug,
   input wire logic o_wdt_run,
   input wire logic [7:0] o_wdt_divide
);
   // ****************************************************************
   // Properties; all of them sleep while reset is asserted.
   // ****************************************************************
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_resetn);
   sequence s_tbl_req;
      i_tbl_rd || i_tbl_wr;
   endsequence
   sequence s_cfg_wr;
      i_tbl_wr && !i_tbl_rd && (i_tbl_addr >= 22'h300000);
   endsequence
   sequence s_answer_no_store;
      o_tbl_done && !o_mem_wr;
   endsequence
   property p_done_next;
      s_tbl_req |=> o_tbl_done;
   endproperty
   property p_done_cause;
      o_tbl_done |-> $past(i_tbl_rd || i_tbl_wr);
   endproperty
   property p_denied_zero;
      (o_tbl_denied || !o_tbl_done) |-> o_tbl_rdata == 8'h00;
   endproperty
   property p_cfg_wr_no_mem;
      s_cfg_wr |=> s_answer_no_store;
   endproperty
   property p_mem_wr_ok;
      o_mem_wr |-> o_tbl_done && !o_tbl_denied && $past(i_tbl_wr && !i_tbl_rd);
   endproperty
   property p_divide_onehot;
      $onehot(o_wdt_divide);
   endproperty
   property p_soft_run;
      i_soft_wdt_en |=> o_wdt_run;
   endproperty
   property p_lowv_one;
      i_lowv_entry_req |=> (o_lowv_accept ^ o_lowv_refused);
   endproperty
   property p_stack_cause;
      o_stack_reset |-> $past(i_stack_full || i_stack_underflow);
   endproperty
   property p_debug_pair;
      o_portb_pin6_debug == o_portb_pin7_debug;
   endproperty
   // A granted write of the watchdog byte shows up on the watchdog outputs two edges later.
   sequence s_wdt_cfg_taken;
      (i_tbl_wr && !i_tbl_rd && (i_tbl_addr == 22'h300003)) ##1 !o_tbl_denied;
   endsequence
   property p_wdt_cfg;
      s_wdt_cfg_taken |=> (o_wdt_divide == (8'h01 << $past(i_tbl_wdata[3:1], 2)))
         && (o_wdt_run == ($past(i_tbl_wdata[0], 2) || $past(i_soft_wdt_en)));
   endproperty
   a_done_next: assert property (p_done_next) else $error("table request not answered");
   a_done_cause: assert property (p_done_cause) else $error("answer without request");
   a_denied_zero: assert property (p_denied_zero) else $error("read data not zero");
   a_cfg_wr_no_mem: assert property (p_cfg_wr_no_mem) else $error("config write reached memory");
   a_mem_wr_ok: assert property (p_mem_wr_ok) else $error("memory write without granted write");
   a_divide_onehot: assert property (p_divide_onehot) else $error("divide ratio not a power of two");
   a_soft_run: assert property (p_soft_run) else $error("watchdog off with soft enable set");
   a_lowv_one: assert property (p_lowv_one) else $error("entry request not answered once");
   a_stack_cause: assert property (p_stack_cause) else $error("stack reset without fault");
   a_debug_pair: assert property (p_debug_pair) else $error("debug pins disagree");
   a_wdt_cfg: assert property (p_wdt_cfg) else $error("watchdog setting mismatch");
endmodule : config_fuse_checker

bind config_fuse_protection config_fuse_checker u_checker (
   .i_mclk(i_mclk), .i_resetn(i_resetn), .i_tbl_rd(i_tbl_rd), .i_tbl_wr(i_tbl_wr),
   .i_tbl_addr(i_tbl_addr), .i_tbl_wdata(i_tbl_wdata), .i_soft_wdt_en(i_soft_wdt_en),
   .i_lowv_entry_req(i_lowv_entry_req),
   .i_stack_full(i_stack_full), .i_stack_underflow(i_stack_underflow), .o_tbl_done(o_tbl_done),
   .o_tbl_rdata(o_tbl_rdata), .o_tbl_denied(o_tbl_denied), .o_mem_wr(o_mem_wr),
   .o_lowv_accept(o_lowv_accept), .o_lowv_refused(o_lowv_refused), .o_stack_reset(o_stack_reset),
   .o_portb_pin6_debug(o_portb_pin6_debug), .o_portb_pin7_debug(o_portb_pin7_debug),
   .o_wdt_run(o_wdt_run), .o_wdt_divide(o_wdt_divide)
);

// *** tb/tb_config_fuse_protection.sv ***
// Self-checking bench for the configuration fuse block.
`timescale 1ns/1ps
module tb_config_fuse_protection
   import config_fuse_pkg::*;
;
   logic i_mclk = 1'h0, i_resetn = 1'h0, i_prog_mode = 1'h0, i_tbl_rd = 1'h0, i_tbl_wr = 1'h0;
   logic i_soft_wdt_en = 1'h0, i_lowv_entry_req = 1'h0, i_stack_full = 1'h0;
   logic i_stack_underflow = 1'h0, i_ee_wr_req = 1'h0;
   addr_type i_tbl_addr = 22'h0, i_exec_addr = 22'h0, o_mem_addr;
   byte_type i_tbl_wdata = 8'h00, i_mem_rdata = 8'h00, o_tbl_rdata, o_mem_wdata;
   logic o_tbl_done, o_tbl_denied, o_mem_wr, o_ee_wr, o_ee_wr_blocked, o_lowv_accept, o_lowv_refused;
   logic o_stack_reset, o_portb_pin6_debug, o_portb_pin7_debug, o_wdt_run;
   logic [5:0] o_code_protect;
   logic [7:0] o_wdt_divide;
   int err_count = 0;
   int cmp_count = 0;
   addr_type cfg_addr[8] = '{22'h300003, 22'h300006, 22'h300008, 22'h300009,
                             22'h30000A, 22'h30000B, 22'h30000C, 22'h30000D};
   byte_type cfg_blank[8] = '{8'h0F, 8'h85, 8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};

   config_fuse_protection dut (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_prog_mode(i_prog_mode), .i_tbl_rd(i_tbl_rd),
      .i_tbl_wr(i_tbl_wr), .i_tbl_addr(i_tbl_addr), .i_tbl_wdata(i_tbl_wdata), .i_exec_addr(i_exec_addr),
      .i_mem_rdata(i_mem_rdata), .i_soft_wdt_en(i_soft_wdt_en), .i_lowv_entry_req(i_lowv_entry_req),
      .i_stack_full(i_stack_full), .i_stack_underflow(i_stack_underflow), .i_ee_wr_req(i_ee_wr_req),
      .o_tbl_done(o_tbl_done), .o_tbl_rdata(o_tbl_rdata), .o_tbl_denied(o_tbl_denied),
      .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_ee_wr(o_ee_wr),
      .o_ee_wr_blocked(o_ee_wr_blocked), .o_lowv_accept(o_lowv_accept), .o_lowv_refused(o_lowv_refused),
      .o_stack_reset(o_stack_reset), .o_portb_pin6_debug(o_portb_pin6_debug),
      .o_portb_pin7_debug(o_portb_pin7_debug), .o_code_protect(o_code_protect),
      .o_wdt_run(o_wdt_run), .o_wdt_divide(o_wdt_divide)
   );

   always #20 i_mclk = ~i_mclk;

   // ****************************************************************
   // Access and compare tasks.
   // ****************************************************************
   task automatic check_val(input string what, input logic [21:0] exp, input logic [21:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val

   task automatic check_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   task automatic do_reset(input logic prog);
      @(posedge i_mclk);
      i_resetn <= 1'h0;
      i_prog_mode <= prog;
      repeat (6) @(posedge i_mclk);
      i_resetn <= 1'h1;
   endtask : do_reset

   task automatic settle;
      @(posedge i_mclk);
      #1;
   endtask : settle

   // For configuration reads the data argument carries the expected byte.
   task automatic tbl_op(input logic wr, input addr_type addr, input addr_type exec, input byte_type data,
                         input logic deny);
      byte_type exp;
      exp = (wr || deny) ? 8'h00 : ((addr >= 22'h300000) ? data : (addr[7:0] ^ 8'h3C));
      @(posedge i_mclk);
      i_tbl_rd <= !wr;
      i_tbl_wr <= wr;
      i_tbl_addr <= addr;
      i_exec_addr <= exec;
      i_tbl_wdata <= data;
      i_mem_rdata <= addr[7:0] ^ 8'h3C;
      @(posedge i_mclk);
      i_tbl_rd <= 1'h0;
      i_tbl_wr <= 1'h0;
      #1;
      check_bit("done", 1'h1, o_tbl_done);
      check_bit("denied", deny, o_tbl_denied);
      check_val("rdata", 22'(exp), 22'(o_tbl_rdata));
      check_bit("mem_wr", wr && !deny && (addr < 22'h300000), o_mem_wr);
      if (wr && !deny && (addr < 22'h300000))
      begin
         check_val("mem_addr", addr, o_mem_addr);
         check_val("mem_wdata", 22'(data), 22'(o_mem_wdata));
      end
   endtask : tbl_op

   task automatic side_pulse(input logic under, input logic lowv, input logic stk, input logic ee);
      @(posedge i_mclk);
      i_lowv_entry_req <= 1'h1;
      i_stack_full <= !under;
      i_stack_underflow <= under;
      i_ee_wr_req <= 1'h1;
      @(posedge i_mclk);
      i_lowv_entry_req <= 1'h0;
      i_stack_full <= 1'h0;
      i_stack_underflow <= 1'h0;
      i_ee_wr_req <= 1'h0;
      #1;
      check_bit("lowv_accept", lowv, o_lowv_accept);
      check_bit("lowv_refused", !lowv, o_lowv_refused);
      check_bit("stack_reset", stk, o_stack_reset);
      check_bit("ee_wr", ee, o_ee_wr);
      check_bit("ee_blocked", !ee, o_ee_wr_blocked);
   endtask : side_pulse

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   // ****************************************************************
   // Tests.
   // ****************************************************************
   initial
   begin
      do_reset(1'h0);
      settle();
      check_val("divide", 22'h80, 22'(o_wdt_divide));
      check_bit("wdt_run", 1'h1, o_wdt_run);
      check_val("code_prot", 22'h0, 22'(o_code_protect));
      check_bit("pin6_debug", 1'h0, o_portb_pin6_debug);
      for (int k = 0; k < 8; k++)
         tbl_op(1'h0, cfg_addr[k], 22'h0, cfg_blank[k], 1'h0);
      tbl_op(1'h0, 22'h300001, 22'h0, 8'h00, 1'h0);
      $display("test blank done");
      for (int c = 0; c < 8; c++)
      begin
         @(posedge i_mclk);
         i_soft_wdt_en <= c[0];
         tbl_op(1'h1, 22'h300003, 22'h0, 8'(c << 1), 1'h0);
         settle();
         check_val("divide", 22'(1 << c), 22'(o_wdt_divide));
         check_bit("wdt_run", c[0], o_wdt_run);
      end
      @(posedge i_mclk);
      i_soft_wdt_en <= 1'h0;
      tbl_op(1'h1, 22'h300003, 22'h0, 8'hF1, 1'h0);
      tbl_op(1'h0, 22'h300003, 22'h0, 8'h01, 1'h0);
      check_bit("wdt_run", 1'h1, o_wdt_run);
      tbl_op(1'h1, 22'h300006, 22'h0, 8'h00, 1'h0);
      settle();
      check_bit("pin6_debug", 1'h1, o_portb_pin6_debug);
      check_bit("pin7_debug", 1'h1, o_portb_pin7_debug);
      side_pulse(1'h0, 1'h0, 1'h0, 1'h1);
      tbl_op(1'h1, 22'h300006, 22'h0, 8'hFF, 1'h0);
      tbl_op(1'h0, 22'h300006, 22'h0, 8'h85, 1'h0);
      check_bit("pin7_debug", 1'h0, o_portb_pin7_debug);
      side_pulse(1'h1, 1'h1, 1'h1, 1'h1);
      $display("test options done");
      do_reset(1'h1);
      tbl_op(1'h1, 22'h300008, 22'h0, 8'h05, 1'h0);
      tbl_op(1'h1, 22'h300008, 22'h0, 8'h0F, 1'h0);
      tbl_op(1'h0, 22'h300008, 22'h0, 8'h05, 1'h0);
      tbl_op(1'h1, 22'h300009, 22'h0, 8'h40, 1'h0);
      settle();
      check_val("code_prot", 22'h2A, 22'(o_code_protect));
      tbl_op(1'h1, 22'h300009, 22'h0, 8'hC0, 1'h0);
      tbl_op(1'h0, 22'h300009, 22'h0, 8'h40, 1'h0);
      tbl_op(1'h1, 22'h300009, 22'h0, 8'h00, 1'h0);
      settle();
      check_val("code_prot", 22'h3A, 22'(o_code_protect));
      tbl_op(1'h0, 22'h002100, 22'h002100, 8'h00, 1'h1);
      tbl_op(1'h0, 22'h000300, 22'h0, 8'h00, 1'h0);
      tbl_op(1'h0, 22'h0001FF, 22'h0, 8'h00, 1'h1);
      tbl_op(1'h0, 22'h006000, 22'h0, 8'h00, 1'h1);
      $display("test code protect done");
      do_reset(1'h0);
      tbl_op(1'h1, 22'h30000A, 22'h0, 8'h0E, 1'h0);
      tbl_op(1'h1, 22'h000200, 22'h0, 8'h11, 1'h1);
      tbl_op(1'h1, 22'h002000, 22'h0, 8'h22, 1'h0);
      tbl_op(1'h1, 22'h30000B, 22'h0, 8'h00, 1'h0);
      tbl_op(1'h0, 22'h30000B, 22'h0, 8'h20, 1'h0);
      tbl_op(1'h1, 22'h0001FF, 22'h0, 8'h33, 1'h1);
      side_pulse(1'h0, 1'h1, 1'h1, 1'h0);
      @(posedge i_mclk);
      i_prog_mode <= 1'h1;
      tbl_op(1'h1, 22'h30000B, 22'h0, 8'h00, 1'h0);
      tbl_op(1'h1, 22'h30000A, 22'h0, 8'h0F, 1'h1);
      tbl_op(1'h0, 22'h30000A, 22'h0, 8'h0E, 1'h0);
      $display("test write protect done");
      do_reset(1'h0);
      tbl_op(1'h1, 22'h30000C, 22'h0, 8'h0B, 1'h0);
      tbl_op(1'h1, 22'h30000D, 22'h0, 8'h00, 1'h0);
      tbl_op(1'h0, 22'h004010, 22'h001000, 8'h00, 1'h1);
      tbl_op(1'h0, 22'h005FFF, 22'h004800, 8'h00, 1'h0);
      tbl_op(1'h0, 22'h000040, 22'h002000, 8'h00, 1'h1);
      tbl_op(1'h0, 22'h000040, 22'h0001FE, 8'h00, 1'h0);
      tbl_op(1'h0, 22'h006000, 22'h000000, 8'h00, 1'h0);
      $display("test table read done");
      tally_and_finish();
   end

   // The tests need well under a thousand cycles; three thousand means a hang.
   initial
   begin
      repeat (3000) @(posedge i_mclk);
      err_count++;
      tally_and_finish();
   end
endmodule : tb_config_fuse_protection
